// *** rtl/osc_ctl_pkg.sv ***
// ==================================================
// oscillator control constants
package osc_ctl_pkg;

  // ==================================================
  // register map, byte offsets on the serial register port
  localparam logic [7:0] CTL_OFFSET = 8'h1c; // oscillator_control
  localparam logic [7:0] STAT_OFFSET = 8'h1d; // active oscillator status, read only
  localparam logic [7:0] KEY_OFFSET = 8'h20; // config_unlock_key
  localparam logic [7:0] CTL_RESET = 8'h00; // control reset value
  localparam logic [7:0] KEY_RESET = 8'h00; // key reset value, locked
  localparam logic [7:0] UNLOCK_VALUE = 8'ha1; // key value that opens the control register
  localparam logic [7:0] ZERO_BYTE = 8'h00; // unmapped reads and reserved bits

  // ==================================================
  // control field layout
  localparam int OSC_SOURCE_SELECT_BIT = 7; // osc_source_select
  localparam int AUTOCAL_MODE_HI = 6; // autocal_mode msb
  localparam int AUTOCAL_MODE_LO = 5; // autocal_mode lsb
  localparam int STAT_RC_BIT = 0; // active_osc_status position in status byte

  // ==================================================
  // autocalibration mode codes
  localparam logic [1:0] AUTOCAL_MODE_OFF = 2'h0; // no autocalibration
  localparam logic [1:0] AUTOCAL_MODE_RSVD = 2'h1; // reserved, no schedule
  localparam logic [1:0] AUTOCAL_MODE_1024S = 2'h2; // long interval
  localparam logic [1:0] AUTOCAL_MODE_512S = 2'h3; // short interval

  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 10; // 100 MHz system clock
  localparam int SECOND_NS = 1000000000; // one second
  localparam int SEC_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS; // clocks per second
  localparam int INTERVAL_LONG_S = 1024; // seconds for code 10
  localparam int INTERVAL_SHORT_S = 512; // seconds for code 11
  localparam int PRESCALE_W = 27; // holds SEC_CYCLES_DEF - 1
  localparam int SECS_W = 10; // holds INTERVAL_LONG_S - 1

  // true only for codes that carry a periodic schedule
  function automatic logic is_sched_mode(input logic [1:0] mode);
    is_sched_mode = (mode == AUTOCAL_MODE_1024S) || (mode == AUTOCAL_MODE_512S);
  endfunction : is_sched_mode

endpackage : osc_ctl_pkg

// *** rtl/autocal_sched.sv ***
`timescale 1ns/100ps
// ==================================================
// periodic autocalibration scheduler
module autocal_sched
  import osc_ctl_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF // clocks per second, shorten in simulation
) (
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic [1:0] mode_in, // current autocal_mode
  input wire logic restart_in, // restart interval, one-cycle pulse
  output logic due_out // interval elapsed, one-cycle pulse
);

  localparam logic [PRESCALE_W-1:0] PRE_LAST = PRESCALE_W'(SEC_CYCLES - 1); // last prescale count
  localparam logic [SECS_W-1:0] LONG_LAST = SECS_W'(INTERVAL_LONG_S - 1); // last second, code 10
  localparam logic [SECS_W-1:0] SHORT_LAST = SECS_W'(INTERVAL_SHORT_S - 1); // last second, code 11

  logic [PRESCALE_W-1:0] pre_q; // clocks within current second
  logic [SECS_W-1:0] secs_q; // seconds since last start
  logic sched; // mode carries a schedule
  logic sec_tick; // one-second enable
  logic last_sec; // final second of interval

  assign sched = is_sched_mode(mode_in);
  assign sec_tick = (pre_q == PRE_LAST);
  assign last_sec = (mode_in == AUTOCAL_MODE_512S) ? (secs_q == SHORT_LAST) : (secs_q == LONG_LAST);
  assign due_out = sched && sec_tick && last_sec && !restart_in;

  // prescaler and second counter; both cleared on restart so a write re-arms a full interval
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || restart_in || !sched) begin
      pre_q <= '0;
      secs_q <= '0;
    end else if (sec_tick) begin
      pre_q <= '0;
      secs_q <= last_sec ? '0 : secs_q + SECS_W'(1);
    end else begin
      pre_q <= pre_q + PRESCALE_W'(1);
    end
  end

  // ==================================================
  // checks
  a_sched_interval_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    due_out |-> (mode_in == AUTOCAL_MODE_512S && secs_q == SHORT_LAST) ||
                (mode_in == AUTOCAL_MODE_1024S && secs_q == LONG_LAST))
    else $error("scheduled start at wrong interval");

endmodule : autocal_sched

// *** rtl/osc_select_ctl.sv ***
`timescale 1ns/100ps
// ==================================================
// oscillator select control register block
module osc_select_ctl
  import osc_ctl_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF // clocks per second, shorten in simulation
) (
  input wire logic clk_in, // system clock, 100 MHz
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic reg_wr_en_in, // register write strobe, one cycle
  input wire logic [7:0] reg_addr_in, // register byte offset
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic xt_running_in, // crystal oscillator is running
  output logic [7:0] reg_rdata_out, // read data for reg_addr_in, one cycle late
  output logic rc_request_out, // osc_source_select: request rc oscillator
  output logic active_osc_status_out, // oscillator in use: 1 rc, 0 crystal
  output logic [1:0] autocal_mode_out, // current autocal_mode field
  output logic autocal_start_out // start one calibration cycle, pulse
);

  // ==================================================
  // storage
  logic [7:0] ctl_q; // oscillator_control
  logic [7:0] key_q; // config_unlock_key
  logic active_rc_q; // oscillator actually clocking timers
  logic active_rc_d; // its next value
  logic start_q; // calibration start pulse
  logic start_d; // its next value
  logic [7:0] rdata_q; // registered read data

  // ==================================================
  // decode
  logic wr_ctl; // write aimed at control
  logic wr_key; // write aimed at key
  logic unlocked; // key holds the unlock value
  logic ctl_accept; // control write that lands
  logic kick_now; // accepted write with nonzero autocal field
  logic sched_due; // scheduler interval elapsed
  logic [7:0] status_byte; // status register image
  logic [7:0] rd_mux; // read selection

  // ==================================================
  // interval watch, feeds the checks only
  // wide enough for the long interval at the full clock rate
  localparam int GAP_W = 40; // clocks since last start, width
  // last clock of a code 11 interval
  localparam logic [GAP_W-1:0] SHORT_GAP_LAST = GAP_W'(INTERVAL_SHORT_S) * GAP_W'(SEC_CYCLES) - GAP_W'(1);
  // last clock of a code 10 interval
  localparam logic [GAP_W-1:0] LONG_GAP_LAST = GAP_W'(INTERVAL_LONG_S) * GAP_W'(SEC_CYCLES) - GAP_W'(1);
  logic [GAP_W-1:0] gap_q; // clocks since the last start pulse

  assign wr_ctl = reg_wr_en_in && (reg_addr_in == CTL_OFFSET);
  assign wr_key = reg_wr_en_in && (reg_addr_in == KEY_OFFSET);
  assign unlocked = (key_q == UNLOCK_VALUE);
  assign ctl_accept = wr_ctl && unlocked;
  // any nonzero code kicks a cycle, reserved included; only scheduled codes repeat
  assign kick_now = ctl_accept && (reg_wdata_in[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO] != AUTOCAL_MODE_OFF);

  // reserved bits of the status byte read as zero
  assign status_byte = ZERO_BYTE | (8'(active_rc_q) << STAT_RC_BIT);

  // unmapped offsets answer zero
  assign rd_mux = (reg_addr_in == CTL_OFFSET) ? ctl_q :
                  (reg_addr_in == KEY_OFFSET) ? key_q :
                  (reg_addr_in == STAT_OFFSET) ? status_byte : ZERO_BYTE;

  // ==================================================
  // oscillator switching
  // rc request always honoured; crystal only once it runs, otherwise hold current source
  assign active_rc_d = ctl_q[OSC_SOURCE_SELECT_BIT] ? 1'b1 :
                       (xt_running_in ? 1'b0 : active_rc_q);

  // ==================================================
  // calibration start
  // immediate kick or a scheduled interval; codes 00 and 01 never schedule
  assign start_d = kick_now || sched_due;

  // ==================================================
  // key register, holds until rewritten
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      key_q <= KEY_RESET;
    end else if (wr_key) begin
      key_q <= reg_wdata_in;
    end
  end

  // control register, locked writes are dropped silently
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctl_q <= CTL_RESET;
    end else if (ctl_accept) begin
      ctl_q <= reg_wdata_in;
    end
  end

  // source status and start pulse
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      active_rc_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      active_rc_q <= active_rc_d;
      start_q <= start_d;
    end
  end

  // read data register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= ZERO_BYTE;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  // gap watch restarts on every start, immediate or scheduled, so it counts independently of the scheduler
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_d) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + GAP_W'(1);
    end
  end

  // ==================================================
  // interval scheduler; restart on any accepted write so the period counts from it
  autocal_sched #(
    .SEC_CYCLES(SEC_CYCLES)
  ) autocal_sched_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .mode_in(ctl_q[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO]),
    .restart_in(ctl_accept),
    .due_out(sched_due)
  );

  // ==================================================
  // outputs, all from flops
  assign reg_rdata_out = rdata_q;
  assign rc_request_out = ctl_q[OSC_SOURCE_SELECT_BIT];
  assign active_osc_status_out = active_rc_q;
  assign autocal_mode_out = ctl_q[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO];
  assign autocal_start_out = start_q;

  // ==================================================
  // checks
  // a wrong key must leave the control byte untouched
  a_locked_write_dropped: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_ctl && !unlocked) |=> $stable(ctl_q))
    else $error("locked control write changed register");

  // the unlock value opens the register for the very next write
  a_unlocked_write_lands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_ctl && unlocked) |=> (ctl_q == $past(reg_wdata_in)))
    else $error("unlocked control write not stored");

  // no waiting for the schedule after a nonzero mode write
  a_kick_immediate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_ctl && unlocked && reg_wdata_in[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO] != AUTOCAL_MODE_OFF) |=> autocal_start_out)
    else $error("nonzero autocal write gave no start");

  // request first, then the status follows one clock later
  a_rc_requested: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ctl_accept && reg_wdata_in[OSC_SOURCE_SELECT_BIT]) |=> rc_request_out ##1 active_osc_status_out)
    else $error("rc select not followed by rc in use");

  // codes 00 and 01 only start on a write, never on their own
  a_off_no_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!is_sched_mode(ctl_q[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO]) && !ctl_accept) |=> !autocal_start_out)
    else $error("start without schedule or write");

  // a running crystal is taken as soon as it is selected
  a_xt_switch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!ctl_q[OSC_SOURCE_SELECT_BIT] && xt_running_in) |=> !active_osc_status_out)
    else $error("crystal running but not selected");

  // a stopped crystal must never be switched in
  a_xt_absent_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!ctl_q[OSC_SOURCE_SELECT_BIT] && !xt_running_in) |=> $stable(active_osc_status_out))
    else $error("switched to crystal while it is stopped");

  // scheduled start lands exactly one short interval after the previous start
  a_short_gap_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sched_due && autocal_mode_out == AUTOCAL_MODE_512S) |-> (gap_q == SHORT_GAP_LAST))
    else $error("code 11 start off the short interval");

  // and it is not skipped when that interval runs out
  a_short_gap_due: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (autocal_mode_out == AUTOCAL_MODE_512S && gap_q == SHORT_GAP_LAST && !ctl_accept) |-> sched_due)
    else $error("code 11 start missing at end of interval");

  // code 10 keeps its own, longer interval
  a_long_gap_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sched_due && autocal_mode_out == AUTOCAL_MODE_1024S) |-> (gap_q == LONG_GAP_LAST))
    else $error("code 10 start off the long interval");

  // while rc is requested the status must report rc
  a_rc_forces_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rc_request_out |=> active_osc_status_out)
    else $error("rc requested but not in use");

  // the key itself is never locked, otherwise the block could not be opened
  a_key_always_stored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_key |=> (key_q == $past(reg_wdata_in)))
    else $error("key write not stored");

  c_unlocked_write: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_key ##1 ctl_accept);
  c_scheduled_start: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    sched_due);
  c_back_to_xt: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    active_osc_status_out ##1 !active_osc_status_out);
  // reserved code kicks once and a locked write is dropped
  c_reserved_kick: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_accept && reg_wdata_in[AUTOCAL_MODE_HI:AUTOCAL_MODE_LO] == AUTOCAL_MODE_RSVD);
  c_locked_drop: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctl && !unlocked);

endmodule : osc_select_ctl

// *** test/tb_top.sv ***
`timescale 1ns/100ps
// ==================================================
// self-checking bench for the oscillator select control block
module tb_top;
  import osc_ctl_pkg::*;
  localparam int SEC = 4; // shortened second keeps the schedule run small
  localparam int BOUND = 4200; // longest wait for a scheduled start
  logic clk_in = 1'b0; // system clock
  logic sys_rst_in; // sync reset, set by the reset task at time zero
  logic reg_wr_en_in = 1'b0; // write strobe
  logic [7:0] reg_addr_in = 8'h00; // register offset
  logic [7:0] reg_wdata_in = 8'h00; // write data
  logic xt_running_in = 1'b0; // crystal not running at first
  logic [7:0] reg_rdata_out; // read data
  logic rc_request_out; // rc requested
  logic active_osc_status_out; // oscillator in use
  logic [1:0] autocal_mode_out; // current autocal mode
  logic autocal_start_out; // calibration start pulse
  int bad_count = 0; // mismatches seen
  int num_checks = 0; // comparisons made

  always #5 clk_in = ~clk_in; // 100 MHz

  osc_select_ctl #(.SEC_CYCLES(SEC)) osc_select_ctl_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_wr_en_in(reg_wr_en_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .xt_running_in(xt_running_in),
    .reg_rdata_out(reg_rdata_out),
    .rc_request_out(rc_request_out),
    .active_osc_status_out(active_osc_status_out),
    .autocal_mode_out(autocal_mode_out),
    .autocal_start_out(autocal_start_out)
  );

  // ==================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin // four-state compare, x matches only x
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // strobe is left high so back-to-back writes never assign it twice in one step
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_wr_en_in = 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask : wr

  task automatic idle(input int n);
    reg_wr_en_in = 1'b0;
    repeat (n) @(negedge clk_in);
  endtask : idle

  // read data is registered, so it is judged one edge after the address
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr_in = addr;
    @(posedge clk_in);
    @(negedge clk_in);
    check(reg_rdata_out, exp);
  endtask : rd

  // ==================================================
  // scenarios
  task automatic t_reset;
    sys_rst_in = 1'b1;
    idle(2);
    sys_rst_in = 1'b0;
    check({rc_request_out, active_osc_status_out, autocal_mode_out, autocal_start_out}, 5'h00);
    rd(CTL_OFFSET, 8'h00);
    rd(KEY_OFFSET, KEY_RESET);
  endtask : t_reset

  task automatic t_locked;
    wr(KEY_OFFSET, 8'ha0); // one bit short of the unlock value
    wr(CTL_OFFSET, 8'he0);
    check({rc_request_out, autocal_mode_out, autocal_start_out}, 4'h0);
    idle(1);
    rd(CTL_OFFSET, 8'h00);
  endtask : t_locked

  task automatic t_select_rc;
    wr(KEY_OFFSET, UNLOCK_VALUE);
    wr(CTL_OFFSET, 8'h9f); // key written the cycle before must already open the register
    check(rc_request_out, 1'b1);
    check(autocal_start_out, 1'b0);
    idle(1);
    check(active_osc_status_out, 1'b1);
    rd(STAT_OFFSET, 8'h01);
    rd(CTL_OFFSET, 8'h9f);
    rd(8'h7f, 8'h00);
  endtask : t_select_rc

  task automatic t_crystal;
    wr(CTL_OFFSET, 8'h00);
    idle(3); // crystal still stopped: switch must not happen
    check(rc_request_out, 1'b0);
    check(active_osc_status_out, 1'b1);
    xt_running_in = 1'b1;
    idle(2);
    check(active_osc_status_out, 1'b0);
    wr(STAT_OFFSET, 8'hff); // status is read only
    idle(1);
    rd(STAT_OFFSET, 8'h00);
  endtask : t_crystal

  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin // every mode code
      wr(CTL_OFFSET, {1'b0, i[1:0], 5'h00});
      check(autocal_mode_out, i[1:0]);
      check(autocal_start_out, i != 0);
      idle(1);
      check(autocal_start_out, 1'b0);
    end
  endtask : t_modes

  // counts cycles from the write-time start to the next scheduled one
  task automatic t_period(input logic [1:0] code, input int exp);
    int n;
    wr(CTL_OFFSET, {1'b0, code, 5'h00});
    reg_wr_en_in = 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (n < BOUND && autocal_start_out !== 1'b1);
    check(n, exp);
    if (exp < BOUND && n == BOUND) begin // lost pulse: stop rather than cascade
      tally_and_finish();
    end
  endtask : t_period

  // ==================================================
  // main sequence
  initial begin
    t_reset();
    t_locked();
    t_select_rc();
    t_crystal();
    t_modes();
    t_period(AUTOCAL_MODE_512S, INTERVAL_SHORT_S * SEC);
    t_period(AUTOCAL_MODE_1024S, INTERVAL_LONG_S * SEC);
    t_period(AUTOCAL_MODE_RSVD, BOUND);
    t_reset(); // second reset mid-run clears key and control
    tally_and_finish();
  end
endmodule : tb_top
